//--- logic/fsl_pkg.sv
// Purpose: Shared constants for the frame sync logic block.
// Assumes: mclk at 125 MHz; all frame timing counted in half-line ticks.
// Notes:   Window and free-run defaults are in ticks since saw-tooth reset.
package fsl_pkg;

  // Clock and half-line tick
  localparam int CLK_PERIOD_NS = 8;
  localparam int HALF_LINE_US  = 32;
  localparam int TICK_CYC      = (HALF_LINE_US * 1000) / CLK_PERIOD_NS;

  // Frame timing in ticks
  localparam int FCNT_W        = 10;
  localparam int BLANK_US      = 1344;
  localparam int BLANK_TICKS   = BLANK_US / HALF_LINE_US;
  localparam int ID50_DELAY_US = 20000;
  localparam int ID50_TICKS    = ID50_DELAY_US / HALF_LINE_US;
  localparam int DISCH_TICKS   = 2;
  localparam int ID50_DEPTH    = 2;
  localparam int ID60_DEPTH    = 3;

  // Register byte offsets
  localparam logic [5:0] OFF_CTRL   = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_WR50   = 6'h08;
  localparam logic [5:0] OFF_WR60   = 6'h0c;
  localparam logic [5:0] OFF_WIDE   = 6'h10;
  localparam logic [5:0] OFF_NAR50  = 6'h14;
  localparam logic [5:0] OFF_NAR60  = 6'h18;
  localparam logic [5:0] OFF_FREE   = 6'h1c;
  localparam logic [5:0] OFF_FREE60 = 6'h20;

  // Field positions: window registers hold lo in [9:0], hi in [25:16]
  localparam int FLD_LO      = 0;
  localparam int FLD_HI      = 16;
  localparam int BIT_VCR     = 0;
  localparam int BIT_ID50    = 0;
  localparam int BIT_ID60    = 1;
  localparam int BIT_TXP     = 2;
  localparam int BIT_BLANK   = 3;
  localparam int BIT_DISCH   = 4;
  localparam int FLD_FCNT    = 16;

  // Reset values of the registers, in ticks
  localparam logic [9:0] RST_WR50_LO  = 10'h26c; // 620
  localparam logic [9:0] RST_WR50_HI  = 10'h276; // 630
  localparam logic [9:0] RST_WR60_LO  = 10'h208; // 520
  localparam logic [9:0] RST_WR60_HI  = 10'h212; // 530
  localparam logic [9:0] RST_WIDE_LO  = 10'h1f4; // 500
  localparam logic [9:0] RST_WIDE_HI  = 10'h2bc; // 700
  localparam logic [9:0] RST_NAR50_LO = 10'h26c;
  localparam logic [9:0] RST_NAR50_HI = 10'h276;
  localparam logic [9:0] RST_NAR60_LO = 10'h208;
  localparam logic [9:0] RST_NAR60_HI = 10'h212;
  localparam logic [9:0] RST_FREE     = 10'h2ce; // 718, about 23 ms
  localparam logic [9:0] RST_FREE_MUTE = 10'h280; // 640, about 49 Hz
  localparam logic [9:0] RST_FREE60   = 10'h230; // 560

endpackage : fsl_pkg

//--- logic/fsl_std_ident.sv
// Purpose: One standard recogniser: shift register of in-window pulses.
// Assumes: hit and frame_end are single-cycle, aligned to the tick.
// Notes:   ident rises DELAY ticks after DEPTH successive frames hit.
module fsl_std_ident
  import fsl_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int DELAY = 0
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic tick,
  input  wire logic hit,
  input  wire logic frame_end,
  output logic      ident
);

  logic             seen_q;
  logic [DEPTH-1:0] shreg_q;
  logic [DEPTH-1:0] shreg_d;
  logic [9:0]       dly_q;
  logic             arm_q;
  logic             ident_q;
  wire              full_d = &shreg_d;

  // A hit in the closing tick still counts for the frame that ends
  assign shreg_d = {shreg_q[DEPTH-2:0], seen_q | hit};
  assign ident   = ident_q;

  // Hit memory and shift register, loaded once per frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_q  <= 1'b0;
      shreg_q <= '0;
    end else if (frame_end) begin
      seen_q  <= 1'b0;
      shreg_q <= shreg_d;
    end else if (hit) begin
      seen_q  <= 1'b1;
    end
  end

  // Identification with its confirmation delay
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dly_q   <= '0;
      arm_q   <= 1'b0;
      ident_q <= 1'b0;
    end else if (frame_end && !full_d) begin
      arm_q   <= 1'b0;
      ident_q <= 1'b0;
    end else if (frame_end && !ident_q && !arm_q) begin
      arm_q   <= (DELAY != 0);
      ident_q <= (DELAY == 0);
      dly_q   <= '0;
    end else if (arm_q && tick) begin
      if (dly_q == 10'(DELAY - 1)) begin
        arm_q   <= 1'b0;
        ident_q <= 1'b1;
      end
      dly_q <= dly_q + 10'h001;
    end
  end

endmodule : fsl_std_ident

//--- logic/fsl_frame_logic.sv
// Purpose: Frame logic of a vertical deflection stage: half-line timing,
//          50/60 Hz recognition, sync windows, saw-tooth reset, blanking.
// Assumes: Inputs synchronous to mclk; Avalon-MM slave with waitrequest.
// Notes:   All frame times are counted in 32 us half-line ticks.
// Operation
// - Logic advances on a 32 us half-line tick; all times count ticks.
// - Line x point lies 64 us times (x-1) plus 32 us after reset.
// - Two shift registers, one per standard, loaded by in-window pulses.
// - 50 Hz identification needs two successive pulses in its window.
// - First pulse resets counters; second sets 50 Hz flag 20 ms later.
// - 50 Hz flag stays low without two successive in-window pulses.
// - With 50 Hz identified the sync window narrows.
// - Sync only takes effect at end of scan, at saw-tooth reset.
// - Logic drives discharge transistor; discharge is the frame reset.
// - 60 Hz recognised drives the slope boost current enable.
// - Sync decisions are locked to the half-line tick.
// - Blanking output covers flyback and guards tube on scan failure.
// - 60 Hz flag needs three successive pulses at the 60 Hz period.
// - Without transmission, sync is off and frame free-runs near 50 Hz.
// - In recorder mode the sync window always stays wide.
// - Blanking starts with flyback and lasts 1.344 ms, 21 lines.
module fsl_frame_logic
  import fsl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        sync_threshold_comparator,
  input  wire logic        tx_present,
  input  wire logic        scan_ok,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             sawtooth_discharge,
  output logic             slope_boost_enable,
  output logic             frame_blank,
  output logic             half_line_tick
);

  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  localparam logic [5:0]  BLANK_N   = 6'(BLANK_TICKS);
  localparam logic [1:0]  DISCH_N   = 2'(DISCH_TICKS);

  // Half-line tick and frame counter
  logic [11:0]       tick_cnt_q;
  logic              tick_q;
  logic [FCNT_W-1:0] fcnt_q;

  // Sync capture
  logic              comp_prev_q;
  logic              sync_seen_q;

  // Outputs and their timers
  logic [1:0]        disch_cnt_q;
  logic              disch_q;
  logic [5:0]        blank_cnt_q;
  logic              blank_q;
  logic              boost_q;

  // Software registers
  logic              vcr_q;
  logic [9:0]        wr50_lo_q;
  logic [9:0]        wr50_hi_q;
  logic [9:0]        wr60_lo_q;
  logic [9:0]        wr60_hi_q;
  logic [9:0]        wide_lo_q;
  logic [9:0]        wide_hi_q;
  logic [9:0]        nar50_lo_q;
  logic [9:0]        nar50_hi_q;
  logic [9:0]        nar60_lo_q;
  logic [9:0]        nar60_hi_q;
  logic [9:0]        free_q;
  logic [9:0]        free_mute_q;
  logic [9:0]        free60_q;

  // Bus handshake
  logic              wait_q;
  logic [31:0]       rdata_q;

  logic              id50;
  logic              id60;

  // Window decode against the frame counter
  wire in_wr50  = (fcnt_q >= wr50_lo_q) && (fcnt_q <= wr50_hi_q);
  wire in_wr60  = (fcnt_q >= wr60_lo_q) && (fcnt_q <= wr60_hi_q);
  wire in_wide  = (fcnt_q >= wide_lo_q) && (fcnt_q <= wide_hi_q);
  wire in_nar50 = (fcnt_q >= nar50_lo_q) && (fcnt_q <= nar50_hi_q);
  wire in_nar60 = (fcnt_q >= nar60_lo_q) && (fcnt_q <= nar60_hi_q);

  // Narrow windows only once a standard is known and not in recorder mode
  wire use_nar50 = id50 && !vcr_q;
  wire use_nar60 = id60 && !id50 && !vcr_q;
  wire in_sync_win = use_nar50 ? in_nar50 :
                     use_nar60 ? in_nar60 : in_wide;

  // Pulses are judged only on a tick, which keeps interlaced fields apart
  wire sync_ev   = tick_q && sync_seen_q;
  wire sync_ok   = sync_ev && tx_present;
  wire hit50     = sync_ok && in_wr50;
  wire hit60     = sync_ok && in_wr60;
  wire sync_acc  = sync_ok && in_sync_win;

  // Free-run limit: mute, lost 60 Hz pulses, or the long default
  wire [9:0] free_lim = !tx_present ? free_mute_q :
                        id60        ? free60_q : free_q;
  wire free_end  = tick_q && (fcnt_q >= free_lim);
  wire frame_end = sync_acc || free_end;

  // Bus decode
  wire req       = read || write;
  wire wr_en     = write && !wait_q;
  wire sel_ctrl  = (address == OFF_CTRL);
  wire sel_stat  = (address == OFF_STATUS);
  wire sel_wr50  = (address == OFF_WR50);
  wire sel_wr60  = (address == OFF_WR60);
  wire sel_wide  = (address == OFF_WIDE);
  wire sel_nar50 = (address == OFF_NAR50);
  wire sel_nar60 = (address == OFF_NAR60);
  wire sel_free  = (address == OFF_FREE);
  wire sel_fr60  = (address == OFF_FREE60);

  wire [9:0] wd_lo = writedata[FLD_LO +: 10];
  wire [9:0] wd_hi = writedata[FLD_HI +: 10];

  wire [31:0] st_word = {6'h00, fcnt_q, 11'h000, disch_q, blank_q,
                         tx_present, id60, id50};

  // Unmapped addresses read as zero
  wire [31:0] rd_mux =
    sel_ctrl  ? {31'h0, vcr_q} :
    sel_stat  ? st_word :
    sel_wr50  ? {6'h00, wr50_hi_q, 6'h00, wr50_lo_q} :
    sel_wr60  ? {6'h00, wr60_hi_q, 6'h00, wr60_lo_q} :
    sel_wide  ? {6'h00, wide_hi_q, 6'h00, wide_lo_q} :
    sel_nar50 ? {6'h00, nar50_hi_q, 6'h00, nar50_lo_q} :
    sel_nar60 ? {6'h00, nar60_hi_q, 6'h00, nar60_lo_q} :
    sel_free  ? {6'h00, free_mute_q, 6'h00, free_q} :
    sel_fr60  ? {22'h0, free60_q} : 32'h0000_0000;

  // Half-line tick from mclk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 12'h000
                                              : tick_cnt_q + 12'h001;
    end
  end

  // Tick count since saw-tooth reset; line x sits at count 2x-1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fcnt_q <= '0;
    end else if (frame_end) begin
      fcnt_q <= '0;
    end else if (tick_q && fcnt_q != '1) begin
      fcnt_q <= fcnt_q + 10'h001;
    end
  end

  // Comparator edge held until the next tick; a new edge beats the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      comp_prev_q <= 1'b0;
      sync_seen_q <= 1'b0;
    end else begin
      comp_prev_q <= sync_threshold_comparator;
      if (sync_threshold_comparator && !comp_prev_q) begin
        sync_seen_q <= 1'b1;
      end else if (tick_q) begin
        sync_seen_q <= 1'b0;
      end
    end
  end

  // 50 Hz recogniser: two frames, then a 20 ms confirmation
  fsl_std_ident #(
    .DEPTH (ID50_DEPTH),
    .DELAY (ID50_TICKS)
  ) u_id50 (
    .mclk      (mclk),
    .nrst      (nrst),
    .tick      (tick_q),
    .hit       (hit50),
    .frame_end (frame_end),
    .ident     (id50)
  );

  // 60 Hz recogniser: three successive frames, no extra delay
  fsl_std_ident #(
    .DEPTH (ID60_DEPTH),
    .DELAY (0)
  ) u_id60 (
    .mclk      (mclk),
    .nrst      (nrst),
    .tick      (tick_q),
    .hit       (hit60),
    .frame_end (frame_end),
    .ident     (id60)
  );

  // Discharge pulse held a few ticks so the RC fully empties
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      disch_cnt_q <= '0;
      disch_q     <= 1'b0;
    end else if (frame_end) begin
      disch_cnt_q <= DISCH_N;
      disch_q     <= 1'b1;
    end else if (tick_q && disch_cnt_q != 2'h0) begin
      disch_cnt_q <= disch_cnt_q - 2'h1;
      disch_q     <= (disch_cnt_q != 2'h1);
    end
  end

  // Blanking from flyback start for 21 lines, forced on scan failure
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blank_cnt_q <= '0;
    end else if (frame_end) begin
      blank_cnt_q <= BLANK_N;
    end else if (tick_q && blank_cnt_q != 6'h00) begin
      blank_cnt_q <= blank_cnt_q - 6'h01;
    end
  end

  // Output flops; the tube guard wins over the counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blank_q <= 1'b1;
      boost_q <= 1'b0;
    end else begin
      blank_q <= frame_end || (blank_cnt_q != 6'h00) || !scan_ok;
      boost_q <= id60;
    end
  end

  // Handshake: one wait cycle, then the access completes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q  <= !(req && wait_q);
      if (read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Control register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vcr_q <= 1'b0;
    end else if (wr_en && sel_ctrl) begin
      vcr_q <= writedata[BIT_VCR];
    end
  end

  // Recognition window registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr50_lo_q <= RST_WR50_LO;
      wr50_hi_q <= RST_WR50_HI;
      wr60_lo_q <= RST_WR60_LO;
      wr60_hi_q <= RST_WR60_HI;
    end else if (wr_en && sel_wr50) begin
      wr50_lo_q <= wd_lo;
      wr50_hi_q <= wd_hi;
    end else if (wr_en && sel_wr60) begin
      wr60_lo_q <= wd_lo;
      wr60_hi_q <= wd_hi;
    end
  end

  // Sync window registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wide_lo_q  <= RST_WIDE_LO;
      wide_hi_q  <= RST_WIDE_HI;
      nar50_lo_q <= RST_NAR50_LO;
      nar50_hi_q <= RST_NAR50_HI;
      nar60_lo_q <= RST_NAR60_LO;
      nar60_hi_q <= RST_NAR60_HI;
    end else if (wr_en && sel_wide) begin
      wide_lo_q  <= wd_lo;
      wide_hi_q  <= wd_hi;
    end else if (wr_en && sel_nar50) begin
      nar50_lo_q <= wd_lo;
      nar50_hi_q <= wd_hi;
    end else if (wr_en && sel_nar60) begin
      nar60_lo_q <= wd_lo;
      nar60_hi_q <= wd_hi;
    end
  end

  // Free-run limits; keep them above the standard periods so sync can win
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      free_q      <= RST_FREE;
      free_mute_q <= RST_FREE_MUTE;
      free60_q    <= RST_FREE60;
    end else if (wr_en && sel_free) begin
      free_q      <= wd_lo;
      free_mute_q <= wd_hi;
    end else if (wr_en && sel_fr60) begin
      free60_q    <= wd_lo;
    end
  end

  assign readdata           = rdata_q;
  assign waitrequest        = wait_q;
  assign sawtooth_discharge = disch_q;
  assign slope_boost_enable = boost_q;
  assign frame_blank        = blank_q;
  assign half_line_tick     = tick_q;

endmodule : fsl_frame_logic

//--- bench/fsl_frame_logic_monitor.sv
// Purpose: Port-level checks of the frame sync logic.
// Assumes: Bound to fsl_frame_logic; one mclk domain.
// Notes:   Tick counters keep long spans out of the properties.
module fsl_frame_logic_monitor
  import fsl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        sync_threshold_comparator,
  input wire logic        tx_present,
  input wire logic        scan_ok,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        sawtooth_discharge,
  input wire logic        slope_boost_enable,
  input wire logic        frame_blank,
  input wire logic        half_line_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic [15:0] cyc_q;
  logic        seen_q;
  logic        prev_q;
  logic        fr_q;
  logic        heard_q;
  logic [3:0]  dt_q;
  logic [9:0]  ft_q;
  logic        rise_w;
  assign rise_w = sawtooth_discharge & ~prev_q;

  // Cycles since tick, ticks in discharge and in frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cyc_q   <= 16'h0;
      seen_q  <= 1'b0;
      prev_q  <= 1'b0;
      fr_q    <= 1'b0;
      heard_q <= 1'b0;
      dt_q    <= 4'h0;
      ft_q    <= 10'h0;
    end else begin
      cyc_q   <= half_line_tick ? 16'h0 : cyc_q + 16'h1;
      seen_q  <= seen_q | half_line_tick;
      prev_q  <= sawtooth_discharge;
      fr_q    <= fr_q | rise_w;
      heard_q <= rise_w ? tx_present : heard_q | tx_present;
      dt_q    <= sawtooth_discharge ? dt_q + {3'h0, half_line_tick} : 4'h0;
      ft_q    <= rise_w ? 10'h0 : ft_q + {9'h0, half_line_tick};
    end
  end

  tick_period_a: assert property (half_line_tick && seen_q |->
    {16'h0, cyc_q} == TICK_CYCLES - 1) else $error("tick spacing wrong");
  disch_on_tick_a: assert property ($rose(sawtooth_discharge) |->
    $past(half_line_tick)) else $error("discharge off the tick");
  blank_covers_a: assert property (sawtooth_discharge |-> frame_blank)
    else $error("discharge without blanking");
  scan_fail_a: assert property (!scan_ok |=> frame_blank)
    else $error("scan failure not blanked");
  blank_length_a: assert property ($fell(frame_blank) && fr_q &&
    scan_ok && $past(scan_ok, 2) |-> ft_q >= 10'd41 && ft_q <= 10'd43)
    else $error("blanking length wrong");
  disch_length_a: assert property ($fell(sawtooth_discharge) |->
    dt_q >= 4'd2 && dt_q <= 4'd3) else $error("discharge length wrong");
  boost_at_end_a: assert property ($changed(slope_boost_enable) |->
    sawtooth_discharge) else $error("boost changed mid frame");
  free_limit_a: assert property ($rose(sawtooth_discharge) && fr_q |->
    ft_q <= 10'd720) else $error("frame overran free limit");
  mute_period_a: assert property ($rose(sawtooth_discharge) && fr_q &&
    !heard_q |-> ft_q >= 10'd639 && ft_q <= 10'd642)
    else $error("mute period wrong");
  bus_one_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
endmodule : fsl_frame_logic_monitor

bind fsl_frame_logic fsl_frame_logic_monitor #(.TICK_CYCLES(TICK_CYCLES))
  fsl_frame_logic_monitor_i (.mclk(mclk), .nrst(nrst),
  .sync_threshold_comparator(sync_threshold_comparator),
  .tx_present(tx_present), .scan_ok(scan_ok), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .sawtooth_discharge(sawtooth_discharge),
  .slope_boost_enable(slope_boost_enable), .frame_blank(frame_blank),
  .half_line_tick(half_line_tick));

//--- bench/fsl_sync_partner.sv
// Purpose: Far side: sync comparator and saw-tooth discharge switch.
// Assumes: Sync period given in mclk cycles, free of the device tick.
// Notes:   Comparator output is always driven, so idle is a solid low.
module fsl_sync_partner (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        en,
  input  wire logic [31:0] per_cyc,
  input  wire logic        discharge,
  output logic             sync_out,
  output logic [15:0]      saw_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ph_q;

  // One comparator pulse per period, shorter than two ticks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_q     <= 32'h0;
      sync_out <= 1'b0;
    end else begin
      ph_q     <= (ph_q + 32'h1 >= per_cyc) ? 32'h0 : ph_q + 32'h1;
      sync_out <= en && (ph_q < 32'h6);
    end
  end

  // Ramp pinned at zero while the switch conducts
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      saw_level <= 16'h0;
    end else begin
      saw_level <= discharge ? 16'h0 : saw_level + 16'h1;
    end
  end
endmodule : fsl_sync_partner

//--- bench/tb_fsl_frame_logic.sv
// Purpose: Self-checking bench for the frame sync logic.
// Assumes: Short tick of TB_TICK cycles keeps frames brief.
// Notes:   Periods are measured between discharge starts, in ticks.
module tb_fsl_frame_logic
  import fsl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TB_TICK = 4;
  localparam logic [5:0] OFFS [10] = '{OFF_CTRL, OFF_WR50, OFF_WR60,
    OFF_WIDE, OFF_NAR50, OFF_NAR60, OFF_FREE, OFF_FREE60, 6'h24, 6'h3c};
  logic        mclk, nrst, sync_w, tx_present, scan_ok, read, write;
  logic        waitrequest, sawtooth_discharge, slope_boost_enable;
  logic        frame_blank, half_line_tick, src_en, disch_q;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, src_per, lfsr;
  logic [31:0] model_reg [int];
  int          bad_count, check_count, cyc;

  fsl_frame_logic #(.TICK_CYCLES(TB_TICK)) fsl_frame_logic_i (
    .mclk(mclk), .nrst(nrst), .sync_threshold_comparator(sync_w),
    .tx_present(tx_present), .scan_ok(scan_ok), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .sawtooth_discharge(sawtooth_discharge),
    .slope_boost_enable(slope_boost_enable), .frame_blank(frame_blank),
    .half_line_tick(half_line_tick));
  fsl_sync_partner fsl_sync_partner_i (.mclk(mclk), .nrst(nrst),
    .en(src_en), .per_cyc(src_per), .discharge(sawtooth_discharge),
    .sync_out(sync_w), .saw_level());

  // Clock, cycle count and discharge history
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    disch_q <= sawtooth_discharge;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Writable bits per offset; zero means the write is dropped
  function automatic logic [31:0] mask_of(input logic [5:0] a);
    if (a == OFF_CTRL) return 32'h1;
    if (a == OFF_FREE60) return 32'h3ff;
    if (a >= OFF_WR50 && a <= OFF_FREE && a[1:0] == 2'h0) return 32'h03ff03ff;
    return 32'h0;
  endfunction : mask_of
  function automatic logic [31:0] exp_reg(input logic [5:0] a);
    return model_reg.exists(int'(a)) ? model_reg[int'(a)] : 32'h0;
  endfunction : exp_reg
  // A pulse inside the window sets the period, else the free limit does
  function automatic int exp_per(int sp, logic [5:0] w, int fr);
    return (sp >= int'(model_reg[w][9:0]) && sp <= int'(model_reg[w][25:16]))
      ? sp : fr;
  endfunction : exp_per

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic cmp_val(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val
  task automatic cmp_range(string nm, int lo, int hi, int g);
    check_count++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : cmp_range
  // Request held until waitrequest is sampled low
  task automatic bus_op(input logic wr, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) bad_count++;
    if (wr && mask_of(a) != 32'h0) model_reg[int'(a)] = d & mask_of(a);
  endtask : bus_op
  task automatic rd_chk(input logic [5:0] a);
    logic [31:0] q;
    bus_op(1'b0, a, 32'h0, q);
    cmp_val($sformatf("reg %h", a), exp_reg(a), q);
  endtask : rd_chk
  task automatic wait_rise();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(sawtooth_discharge === 1'b1 && disch_q === 1'b0) && n < 4000);
    if (n >= 4000) bad_count++;
  endtask : wait_rise
  task automatic next_per(output int p);
    int c0;
    c0 = cyc;
    wait_rise();
    p = (cyc - c0) / TB_TICK;
  endtask : next_per

  // Watchdog: about 25 frames of the short tick need some 60000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    close_out();
  end

  initial begin
    int n, p, ep;
    logic [31:0] q, sv;
    {nrst, read, write, tx_present, src_en, cyc, disch_q} = '0;
    {address, writedata, bad_count, check_count} = '0;
    scan_ok = 1'b1;
    src_per = 32'd600 * TB_TICK;
    lfsr = 32'h4096;
    model_reg[OFF_CTRL] = 32'h0;
    model_reg[OFF_WR50] = {6'h0, RST_WR50_HI, 6'h0, RST_WR50_LO};
    model_reg[OFF_WR60] = {6'h0, RST_WR60_HI, 6'h0, RST_WR60_LO};
    model_reg[OFF_WIDE] = {6'h0, RST_WIDE_HI, 6'h0, RST_WIDE_LO};
    model_reg[OFF_NAR50] = {6'h0, RST_NAR50_HI, 6'h0, RST_NAR50_LO};
    model_reg[OFF_NAR60] = {6'h0, RST_NAR60_HI, 6'h0, RST_NAR60_LO};
    model_reg[OFF_FREE] = {6'h0, RST_FREE_MUTE, 6'h0, RST_FREE};
    model_reg[OFF_FREE60] = {22'h0, RST_FREE60};
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values, random readback, dropped writes, then restore
    foreach (OFFS[i]) begin
      rd_chk(OFFS[i]);
      sv = exp_reg(OFFS[i]);
      lfsr = lfsr_next(lfsr);
      // Keep limits and windows above the running count, so a random
      // value cannot end frames every tick and skew the length checks
      bus_op(1'b1, OFFS[i], lfsr | 32'h0200_0200, q);
      rd_chk(OFFS[i]);
      bus_op(1'b1, OFFS[i], sv, q);
    end
    bus_op(1'b1, OFF_STATUS, 32'hffffffff, q);
    bus_op(1'b0, OFF_STATUS, 32'h0, q);
    cmp_val("status", 32'h0, q & 32'h7);
    // No transmission: pulses ignored, mute free-run
    src_en <= 1'b1;
    wait_rise();
    next_per(p);
    ep = int'(model_reg[OFF_FREE][25:16]);
    cmp_range("mute period", ep, ep + 1, p);
    wait_rise();
    n = 0;
    while (frame_blank === 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    cmp_range("blank cycles", 41 * TB_TICK, 43 * TB_TICK, n);
    scan_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    cmp_val("blank", 32'h1, {31'h0, frame_blank});
    scan_ok <= 1'b1;
    // 50 Hz capture and identification
    tx_present <= 1'b1;
    src_per <= 32'd625 * TB_TICK;
    repeat (6) wait_rise();
    next_per(p);
    cmp_range("50 Hz period", exp_per(625, OFF_NAR50, 0), 625, p);
    bus_op(1'b0, OFF_STATUS, 32'h0, q);
    cmp_val("id 50", 32'h5, q & 32'h7);
    cmp_val("boost 50", 32'h0, {31'h0, slope_boost_enable});
    // Recorder mode keeps the wide window
    bus_op(1'b1, OFF_CTRL, 32'h1, q);
    wait_rise();
    src_per <= 32'd690 * TB_TICK;
    next_per(p);
    cmp_range("vcr period", exp_per(690, OFF_WIDE, 0), 690, p);
    bus_op(1'b1, OFF_CTRL, 32'h0, q);
    // 60 Hz: three frames to identify, boost follows
    src_per <= 32'd525 * TB_TICK;
    repeat (5) wait_rise();
    next_per(p);
    cmp_range("60 Hz period", exp_per(525, OFF_WIDE, 0), 525, p);
    bus_op(1'b0, OFF_STATUS, 32'h0, q);
    cmp_val("id 60", 32'h6, q & 32'h7);
    cmp_val("boost 60", 32'h1, {31'h0, slope_boost_enable});
    // Narrow window refuses a late pulse; short free limit applies
    wait_rise();
    src_per <= 32'd600 * TB_TICK;
    next_per(p);
    ep = exp_per(600, OFF_NAR60, int'(model_reg[OFF_FREE60]));
    cmp_range("narrow period", ep, ep + int'(ep != 600), p);
    // Sync lost: normal free-run and boost dropped
    src_en <= 1'b0;
    repeat (3) wait_rise();
    next_per(p);
    ep = int'(model_reg[OFF_FREE][9:0]);
    cmp_range("free period", ep, ep + 1, p);
    cmp_val("boost off", 32'h0, {31'h0, slope_boost_enable});
    close_out();
  end
endmodule : tb_fsl_frame_logic
